// ==== rtl/fld_pkg.sv ====
package fld_pkg;

    localparam int APB_AW = 12;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_XOVER = 10'h02c;
    localparam logic [9:0] IDX_CTRL  = 10'h02d;
    localparam logic [9:0] IDX_THR   = 10'h02e;
    localparam logic [9:0] IDX_CFG3  = 10'h031;
    localparam logic [11:0] ADDR_XOVER = {IDX_XOVER, 2'b00};
    localparam logic [11:0] ADDR_CTRL  = {IDX_CTRL, 2'b00};
    localparam logic [11:0] ADDR_THR   = {IDX_THR, 2'b00};
    localparam logic [11:0] ADDR_CFG3  = {IDX_CFG3, 2'b00};

    // reset values and writable masks
    localparam logic [15:0] RST_XOVER = 16'h141f;
    localparam logic [15:0] RST_CTRL  = 16'h0000;
    localparam logic [15:0] RST_THR   = 16'h0221;
    localparam logic [15:0] RST_CFG3  = 16'h10b0;
    localparam logic [15:0] WM_XOVER  = 16'h3fff;
    localparam logic [15:0] WM_CTRL   = 16'hc01f;
    localparam logic [15:0] WM_THR    = 16'h0777;
    localparam logic [15:0] WM_CFG3   = 16'h71fd;

    // field positions
    localparam int WIN_LSB   = 9;
    localparam int QX_LSB    = 4;
    localparam int SX_LSB    = 0;
    localparam int FORCE_BIT = 15;
    localparam int BYP_BIT   = 14;
    localparam int STUCK_BIT = 13;
    localparam int CAUSE_LSB = 8;
    localparam int MODE_LSB  = 0;
    localparam int EWIN_LSB  = 8;
    localparam int EON_LSB   = 4;
    localparam int EOFF_LSB  = 0;
    localparam int AN_LSB    = 5;
    localparam int NCRIT     = 5;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS         = 1000;
    localparam int US_CYCLES     = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MAX_WAIT_US   = 8;
    localparam int AN_T0_NS      = 1600000;
    localparam int AN_T1_NS      = 2000;
    localparam int AN_T2_NS      = 800000;
    localparam int AN_T3_NS      = 11000000;
    localparam int AN_CYC0       = AN_T0_NS / CLK_PERIOD_NS;
    localparam int AN_CYC1       = AN_T1_NS / CLK_PERIOD_NS;
    localparam int AN_CYC2       = AN_T2_NS / CLK_PERIOD_NS;
    localparam int AN_CYC3       = AN_T3_NS / CLK_PERIOD_NS;
    localparam int AN_CW         = 21;

endpackage

// ==== rtl/fld_regs.sv ====
// Summary of operation
// - five-bit window count sets the fast drop observation window, reset 10 us.
// - five-bit quick crossover timer for forced 100M mode, default about 4 ms.
// - four-bit slow crossover timer for robust mode, default half a second.
// - forced drop enable stops transmit whenever no far-end signal is seen.
// - hold-off bypass skips the maximum wait timer so link drops sooner.
// - five-bit cause field latches events and clears when software reads it.
// - five independent criterion enables, any combination may be active.
// - three-bit energy accumulation window, reset value 2.
// - energy detected when accumulator exceeds three-bit threshold, reset 2.
// - energy lost when accumulator falls below three-bit threshold, reset 1.
// - two-bit select picks negotiation timer: 1.6 ms, 2 us, 800 us, 11 ms.
`timescale 1ns/10ps
`default_nettype none
module fld_regs #(
    parameter int ACC_W    = 3,
    parameter int MAX_WAIT = fld_pkg::MAX_WAIT_US,
    parameter int AN_C0    = fld_pkg::AN_CYC0,
    parameter int AN_C1    = fld_pkg::AN_CYC1,
    parameter int AN_C2    = fld_pkg::AN_CYC2,
    parameter int AN_C3    = fld_pkg::AN_CYC3
) (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          ce,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [fld_pkg::APB_AW-1:0]    paddr,
    input  wire logic [31:0]                   pwdata,
    input  wire logic [3:0]                    pstrb,
    output var  logic [31:0]                   prdata,
    output var  logic                          pready,
    output var  logic                          pslverr,
    input  wire logic [ACC_W-1:0]              energy_acc,
    input  wire logic [fld_pkg::NCRIT-1:1]     crit_event,
    input  wire logic                          no_signal,
    input  wire logic                          slicer_stuck,
    output var  logic                          energy_detected,
    output var  logic                          energy_lost,
    output var  logic                          link_drop,
    output var  logic                          tx_stop,
    output var  logic [4:0]                    fast_drop_window_count,
    output var  logic [4:0]                    quick_crossover_timer,
    output var  logic [3:0]                    slow_crossover_timer,
    output var  logic [2:0]                    energy_accumulation_window,
    output var  logic [fld_pkg::AN_CW-1:0]     serial_negotiation_cycles
);
    import fld_pkg::*;

    function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] st, input logic [15:0] wm);
        logic [15:0] be;
        be = {{8{st[1]}}, {8{st[0]}}} & wm;
        return (old & ~be) | (wd[15:0] & be);
    endfunction

    function automatic logic [AN_CW-1:0] an_cycles(input logic [1:0] sel);
        case (sel)
            2'h0:    an_cycles = AN_CW'(AN_C0);
            2'h1:    an_cycles = AN_CW'(AN_C1);
            2'h2:    an_cycles = AN_CW'(AN_C2);
            default: an_cycles = AN_CW'(AN_C3);
        endcase
    endfunction

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_WAIT = 2'b01,
        HS_DROP = 2'b10
    } fld_hold_t;

    logic [15:0]        xover_q, ctl_q, thr_q, cfg3_q;
    logic [NCRIT-1:0]   cause_q, cause_d, pend_q, pend_d;
    logic [6:0]         us_cnt_q;
    logic [4:0]         win_cnt_q;
    logic [7:0]         hold_cnt_q;
    fld_hold_t          hs_q, hs_d;
    logic [31:0]        prdata_q;
    logic               pready_q, pslverr_q, det_q, lost_q, drop_q, txs_q;
    logic [AN_CW-1:0]   an_q;

    // apb decode
    wire setup    = psel & ~penable;
    wire done     = psel & penable & pready_q;
    wire hit_x    = paddr == ADDR_XOVER;
    wire hit_c    = paddr == ADDR_CTRL;
    wire hit_t    = paddr == ADDR_THR;
    wire hit_3    = paddr == ADDR_CFG3;
    wire hit      = hit_x | hit_c | hit_t | hit_3;
    wire wr_en    = done & pwrite & hit;
    wire rd_clear = done & ~pwrite & hit_c;

    wire [15:0] ctl_rd = ctl_q | ({15'h0000, slicer_stuck} << STUCK_BIT)
                        | ({11'h000, cause_q} << CAUSE_LSB);
    // reserved read-only bits are never stored, so they read zero
    wire [15:0] rsel = hit_x ? xover_q : hit_c ? ctl_rd : hit_t ? thr_q
                     : hit_3 ? cfg3_q : 16'h0000;

    // field views
    wire [4:0] win_len  = xover_q[WIN_LSB +: 5];
    wire       force_en = ctl_q[FORCE_BIT];
    wire       bypass   = ctl_q[BYP_BIT];
    wire [NCRIT-1:0] modes = ctl_q[MODE_LSB +: NCRIT];
    wire [2:0] on_thr   = thr_q[EON_LSB +: 3];
    wire [2:0] off_thr  = thr_q[EOFF_LSB +: 3];
    wire [1:0] an_sel   = cfg3_q[AN_LSB +: 2];

    // window timing in microsecond ticks
    wire us_tick = us_cnt_q == 7'(US_CYCLES - 1);
    wire [4:0] win_last = (win_len == 5'h00) ? 5'h00 : win_len - 5'h01;
    wire win_end  = us_tick & (win_cnt_q >= win_last);
    wire [NCRIT-1:0] crit   = {crit_event, lost_q};
    wire [NCRIT-1:0] hits   = pend_q | (crit & modes);
    wire trigger  = win_end & (hits != '0) & (hs_q != HS_WAIT);
    wire hold_end = us_tick & (hold_cnt_q == 8'(MAX_WAIT - 1));

    assign pend_d  = win_end ? '0 : hits;
    // a new event wins over the read clear
    assign cause_d = (rd_clear ? '0 : cause_q) | (trigger ? hits : '0);

    always_comb begin
        hs_d = hs_q;
        case (hs_q)
            HS_IDLE: begin
                if (trigger) begin
                    hs_d = bypass ? HS_DROP : HS_WAIT;
                end
            end
            HS_WAIT: begin
                if (hold_end) begin
                    hs_d = HS_DROP;
                end
            end
            HS_DROP: begin
                hs_d = trigger ? (bypass ? HS_DROP : HS_WAIT) : HS_IDLE;
            end
            default: hs_d = HS_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xover_q <= RST_XOVER;
            ctl_q   <= RST_CTRL;
            thr_q   <= RST_THR;
            cfg3_q  <= RST_CFG3;
        end else if (ce && wr_en) begin
            if (hit_x) xover_q <= wmerge(xover_q, pwdata, pstrb, WM_XOVER);
            if (hit_c) ctl_q   <= wmerge(ctl_q, pwdata, pstrb, WM_CTRL);
            if (hit_t) thr_q   <= wmerge(thr_q, pwdata, pstrb, WM_THR);
            if (hit_3) cfg3_q  <= wmerge(cfg3_q, pwdata, pstrb, WM_CFG3);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (ce) begin
            pready_q  <= setup;
            pslverr_q <= setup & ~hit;
            if (setup) prdata_q <= {16'h0000, pwrite ? 16'h0000 : rsel};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            us_cnt_q   <= 7'h00;
            win_cnt_q  <= 5'h00;
            hold_cnt_q <= 8'h00;
            pend_q     <= '0;
            cause_q    <= '0;
            hs_q       <= HS_IDLE;
        end else if (ce) begin
            us_cnt_q   <= us_tick ? 7'h00 : us_cnt_q + 7'h01;
            if (us_tick) win_cnt_q <= win_end ? 5'h00 : win_cnt_q + 5'h01;
            if (hs_q != HS_WAIT) hold_cnt_q <= 8'h00;
            else if (us_tick) hold_cnt_q <= hold_cnt_q + 8'h01;
            pend_q     <= pend_d;
            cause_q    <= cause_d;
            hs_q       <= hs_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            det_q  <= 1'b0;
            lost_q <= 1'b0;
            drop_q <= 1'b0;
            txs_q  <= 1'b0;
            an_q   <= AN_CW'(AN_C1);
        end else if (ce) begin
            det_q  <= energy_acc > ACC_W'(on_thr);
            lost_q <= energy_acc < ACC_W'(off_thr);
            drop_q <= hs_d == HS_DROP;
            txs_q  <= force_en & no_signal;
            an_q   <= an_cycles(an_sel);
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign energy_detected = det_q;
    assign energy_lost     = lost_q;
    assign link_drop       = drop_q;
    assign tx_stop         = txs_q;
    assign fast_drop_window_count     = win_len;
    assign quick_crossover_timer      = xover_q[QX_LSB +: 5];
    assign slow_crossover_timer       = xover_q[SX_LSB +: 4];
    assign energy_accumulation_window = thr_q[EWIN_LSB +: 3];
    assign serial_negotiation_cycles  = an_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_trig_wait;
        ce && trigger && !bypass && hs_q == HS_IDLE;
    endsequence
    sequence s_no_drop;
        !link_drop;
    endsequence

    property p_force;
        ce |=> tx_stop == ($past(force_en) & $past(no_signal));
    endproperty
    a_force: assert property (p_force) else $error("tx stop not following forced drop");

    property p_bypass;
        ce && trigger && bypass |=> link_drop;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass drop late");

    property p_hold;
        s_trig_wait |=> s_no_drop ##1 s_no_drop;
    endproperty
    a_hold: assert property (p_hold) else $error("hold-off skipped");

    property p_cause_set;
        ce && trigger |=> (cause_q & $past(hits)) == $past(hits);
    endproperty
    a_cause_set: assert property (p_cause_set) else $error("cause not latched");

    property p_cause_clr;
        ce && rd_clear && !trigger |=> cause_q == '0;
    endproperty
    a_cause_clr: assert property (p_cause_clr) else $error("cause not cleared on read");

    property p_enabled_only;
        ce |=> ((cause_q & ~$past(cause_q)) & ~$past(modes) & ~$past(pend_q)) == '0;
    endproperty
    a_enabled_only: assert property (p_enabled_only) else $error("cause from disabled criterion");

    property p_det;
        ce |=> energy_detected == ($past(energy_acc) > ACC_W'($past(on_thr)));
    endproperty
    a_det: assert property (p_det) else $error("energy detect wrong");

    property p_lost;
        ce |=> energy_lost == ($past(energy_acc) < ACC_W'($past(off_thr)));
    endproperty
    a_lost: assert property (p_lost) else $error("energy lost wrong");

    property p_an;
        ce && an_sel == 2'h1 |=> serial_negotiation_cycles == AN_CW'(AN_C1);
    endproperty
    a_an: assert property (p_an) else $error("negotiation timer wrong");

    property p_rsv;
        pready && psel && hit_x |-> prdata[15:14] == 2'b00 && prdata[31:16] == 16'h0000;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits not zero");

    property p_win;
        ce && us_tick && win_len == 5'h0a && win_cnt_q == 5'h09 |=> win_cnt_q == 5'h00;
    endproperty
    a_win: assert property (p_win) else $error("window length wrong");

    property p_wait_quiet;
        ce && hs_q == HS_WAIT && !hold_end |=> !link_drop;
    endproperty
    a_wait_quiet: assert property (p_wait_quiet) else $error("drop during hold-off");

    property p_tx_idle;
        ce && !force_en |=> !tx_stop;
    endproperty
    a_tx_idle: assert property (p_tx_idle) else $error("tx stop without forced drop");

    property p_cause_keep;
        ce && !trigger && !rd_clear |=> cause_q == $past(cause_q);
    endproperty
    a_cause_keep: assert property (p_cause_keep) else $error("cause changed without event");

    property p_unmapped;
        pready && psel && !hit |-> pslverr && prdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

endmodule
`default_nettype wire

// ==== bench/fld_far_end.sv ====
`timescale 1ns/10ps
`default_nettype none
module fld_far_end (
    input  wire logic       pclk,
    output var  logic [2:0] energy_acc,
    output var  logic [4:1] crit_event,
    output var  logic       no_signal,
    output var  logic       slicer_stuck
);
    // far end seen through the receive detectors; starts with a healthy line
    initial begin
        energy_acc = 3'h3;
        crit_event = 4'h0;
        no_signal = 1'b0;
        slicer_stuck = 1'b0;
    end
    task automatic line(input logic [2:0] acc, input logic ns, input logic st);
        @(posedge pclk);
        energy_acc <= acc;
        no_signal <= ns;
        slicer_stuck <= st;
    endtask
    // one-cycle detector event burst
    task automatic pulse(input logic [4:1] ev);
        @(posedge pclk);
        crit_event <= ev;
        @(posedge pclk);
        crit_event <= 4'h0;
    endtask
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module testbench;
    import fld_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  energy_acc;
    logic [4:1]  crit_event;
    logic        no_signal;
    logic        slicer_stuck;
    logic        e_det;
    logic        e_lost;
    logic        link_drop;
    logic        tx_stop;
    logic [4:0]  win_cnt;
    logic [4:0]  qx;
    logic [3:0]  sx;
    logic [2:0]  ewin;
    logic [20:0] an_cyc;
    logic [31:0] rd;
    logic        er;
    int          err_total;
    int          compares;
    int          n;

    fld_regs #(.MAX_WAIT(1)) u_dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .energy_acc(energy_acc), .crit_event(crit_event), .no_signal(no_signal), .slicer_stuck(slicer_stuck),
        .energy_detected(e_det), .energy_lost(e_lost), .link_drop(link_drop), .tx_stop(tx_stop),
        .fast_drop_window_count(win_cnt), .quick_crossover_timer(qx), .slow_crossover_timer(sx),
        .energy_accumulation_window(ewin), .serial_negotiation_cycles(an_cyc));
    fld_far_end u_far (.pclk(pclk), .energy_acc(energy_acc), .crit_event(crit_event),
        .no_signal(no_signal), .slicer_stuck(slicer_stuck));

    task automatic results;
        $display("mismatches %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [11:0] a, input logic [15:0] ex);
        apb(1'b0, a, 32'h0);
        `CHK(nm, {16'h0, ex}, rd)
    endtask
    task automatic wait_drop;
        n = 0;
        while (link_drop !== 1'b1 && n < 400) begin
            @(posedge pclk);
            n++;
        end
    endtask
    function automatic logic [20:0] an_exp(input int c);
        return (c == 0) ? 21'(AN_CYC0) : (c == 1) ? 21'(AN_CYC1) : (c == 2) ? 21'(AN_CYC2) : 21'(AN_CYC3);
    endfunction

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        repeat (50000) @(posedge pclk);
        err_total++;
        results();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        ce = 1'b1;
        pstrb = 4'hf;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        `CHK("win", 5'h0a, win_cnt)
        `CHK("quick", 5'h01, qx)
        `CHK("slow", 4'hf, sx)
        `CHK("ewin", 3'h2, ewin)
        `CHK("an", 21'(AN_CYC1), an_cyc)
        repeat (1100) @(posedge pclk);
        rchk("xover", ADDR_XOVER, 16'h141f);
        rchk("ctrl", ADDR_CTRL, 16'h0000);
        rchk("thr", ADDR_THR, 16'h0221);
        rchk("cfg3", ADDR_CFG3, 16'h10b0);
        apb(1'b0, 12'h0bc, 32'h0);
        `CHK("slverr", 1'b1, er)
        u_far.line(3'h2, 1'b0, 1'b0);
        repeat (3) @(posedge pclk);
        `CHK("edet eq", 1'b0, e_det)
        `CHK("elost eq", 1'b0, e_lost)
        u_far.line(3'h0, 1'b0, 1'b0);
        repeat (3) @(posedge pclk);
        `CHK("elost", 1'b1, e_lost)
        u_far.line(3'h3, 1'b0, 1'b0);
        repeat (3) @(posedge pclk);
        `CHK("edet", 1'b1, e_det)
        apb(1'b1, ADDR_XOVER, 32'hffff_ffff);
        rchk("xover ones", ADDR_XOVER, 16'h3fff);
        `CHK("win max", 5'h1f, win_cnt)
        `CHK("quick max", 5'h1f, qx)
        apb(1'b1, ADDR_CTRL, 32'h0000_3fe0);
        rchk("ctrl ro", ADDR_CTRL, 16'h0000);
        u_far.line(3'h3, 1'b0, 1'b1);
        rchk("stuck", ADDR_CTRL, 16'h2000);
        u_far.line(3'h3, 1'b0, 1'b0);
        apb(1'b1, ADDR_THR, 32'hffff_ffff);
        rchk("thr ones", ADDR_THR, 16'h0777);
        `CHK("ewin max", 3'h7, ewin)
        pstrb <= 4'h1;
        apb(1'b1, ADDR_THR, 32'h0000_0000);
        pstrb <= 4'hf;
        rchk("thr lane", ADDR_THR, 16'h0700);
        apb(1'b1, ADDR_CFG3, 32'hffff_ffff);
        rchk("cfg3 ones", ADDR_CFG3, 16'h71fd);
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, ADDR_CFG3, 32'(c << 5));
            repeat (2) @(posedge pclk);
            `CHK("an sel", an_exp(c), an_cyc)
        end
        apb(1'b1, ADDR_THR, 32'h0000_0221);
        apb(1'b1, ADDR_CTRL, 32'h0000_8000);
        u_far.line(3'h3, 1'b1, 1'b0);
        repeat (3) @(posedge pclk);
        `CHK("tx_stop", 1'b1, tx_stop)
        ce <= 1'b0;
        u_far.line(3'h3, 1'b0, 1'b0);
        repeat (3) @(posedge pclk);
        `CHK("tx_stop frozen", 1'b1, tx_stop)
        ce <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK("tx_stop off", 1'b0, tx_stop)
        apb(1'b1, ADDR_XOVER, 32'h0000_021f);
        apb(1'b1, ADDR_CTRL, 32'h0000_4002);
        u_far.pulse(4'b0011);
        wait_drop();
        `CHK("bypass drop", 1'b1, n <= 110)
        rchk("cause", ADDR_CTRL, 16'h4202);
        rchk("cause clr", ADDR_CTRL, 16'h4002);
        apb(1'b1, ADDR_CTRL, 32'h0000_000a);
        u_far.pulse(4'b0100);
        wait_drop();
        `CHK("held drop", 1'b1, n >= 100 && n <= 215)
        rchk("cause rx", ADDR_CTRL, 16'h080a);
        rchk("cause rx clr", ADDR_CTRL, 16'h000a);
        apb(1'b1, ADDR_CTRL, 32'h0000_4001);
        u_far.line(3'h0, 1'b0, 1'b0);
        wait_drop();
        `CHK("lost drop", 1'b1, n <= 110)
        u_far.line(3'h3, 1'b0, 1'b0);
        repeat (210) @(posedge pclk);
        rchk("cause lost", ADDR_CTRL, 16'h4101);
        rchk("cause lost clr", ADDR_CTRL, 16'h4001);
        results();
    end
endmodule
`undef CHK
`default_nettype wire
